// [common/sac_pkg.sv]
// constants and carrier types for the converter sequencer
// Contract
// - nonzero positive select enables the channel
// - several enabled channels select scan mode
// - one trigger converts every enabled channel; averaging without burst goes idle after each sample but the last of an average
// - negative select used only when differential
// - single-ended default, negative input grounded
// - code range is two to resolution minus m
// - stored samples are 16-bit two's complement
// - 8/10/12 bit; 14 bit only averaged
// - trigger starts acquisition of channel time
// - done event after every single sample
// - no averaging: result-ready equals done
// - averaging: result-ready after full average
// - events may precede the memory write
// - average two to averaging-count samples; a count above 9 takes 512 samples
// - burst takes all averaging samples at once
// - rate timer samples periodically until stop
// - two results per word, ascending channel
// - calibration task ends with complete event
// - end event at capacity, then restart needed
// - stop ends sampling, always stopped event
// - buffer pointer latched at start
package sac_pkg;
  localparam int NUM_CH   = 8;
  localparam int SEL_W    = 4;
  localparam int CODE_W   = 16;
  localparam int SAMPLE_W = 16;
  localparam int WORD_W   = 32;
  localparam int ADDR_W   = 32;
  localparam int CNT_W    = 15;
  localparam int RATE_W   = 11;
  localparam int ACC_W    = 24;
  localparam int AVG_W    = 4;
  localparam int ACQ_W    = 13;
  localparam int CLK_MHZ  = 100;
  localparam logic [SEL_W-1:0] SEL_NC  = 4'h0;
  localparam logic [SEL_W-1:0] SEL_GND = 4'hf;
  localparam logic [1:0] RES_8  = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_14 = 2'h3;
  localparam int BITS_8  = 8;
  localparam int BITS_10 = 10;
  localparam int BITS_12 = 12;
  localparam int BITS_14 = 14;
  localparam int EXTRA_14 = 2;
  localparam int BYTES_PER_WORD = 4;
  // acquisition times in microseconds
  localparam int ACQ_US_0 = 3;
  localparam int ACQ_US_1 = 5;
  localparam int ACQ_US_2 = 10;
  localparam int ACQ_US_3 = 15;
  localparam int ACQ_US_4 = 20;
  localparam int ACQ_US_5 = 40;

  typedef enum logic [2:0] {
    S_IDLE, S_ACQ, S_CONV, S_STORE, S_CAL, S_DRAIN
  } sac_state_t;

  typedef struct packed {
    logic       diffMode;
    logic       burst;
    logic [2:0] acqTime;
    logic       refChoice;
    logic [2:0] gain;
  } sac_chan_setup_t;

  typedef struct packed {
    logic            acquire;
    logic            convert;
    logic            calibrate;
    logic [SEL_W-1:0] posSel;
    logic [SEL_W-1:0] negSel;
    sac_chan_setup_t setup;
  } sac_afe_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } sac_dma_word_t;

  typedef struct packed {
    logic started;
    logic bufferEnd;
    logic done;
    logic resultReady;
    logic calDone;
    logic stopped;
  } sac_events_t;

  typedef struct packed {
    sac_state_t                state;
    logic                      running;
    logic                      stopReq;
    logic                      ending;
    logic                      timerRun;
    logic [RATE_W-1:0]         timer;
    logic [2:0]                chan;
    logic [NUM_CH-1:0]         pending;
    logic [ACQ_W-1:0]          acqCnt;
    logic [8:0]                avgCnt;
    logic signed [ACC_W-1:0]   acc;
    logic [SAMPLE_W-1:0]       result;
    logic [SAMPLE_W-1:0]       halfData;
    logic                      halfFull;
    logic [CNT_W-1:0]          wordIdx;
    logic [CNT_W-1:0]          sampleCnt;
    logic [ADDR_W-1:0]         base;
    logic [CNT_W-1:0]          cap;
    sac_events_t               events;
    sac_afe_req_t              afe;
  } sac_seq_t;

  function automatic logic [ACQ_W-1:0] acq_cycles(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = ACQ_US_0;
      3'h1: us = ACQ_US_1;
      3'h2: us = ACQ_US_2;
      3'h3: us = ACQ_US_3;
      3'h4: us = ACQ_US_4;
      default: us = ACQ_US_5;
    endcase
    return ACQ_W'(us * CLK_MHZ);
  endfunction : acq_cycles
endpackage : sac_pkg

// [rtl/sac_fifo.sv]
// word fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0]   count;
  logic [PTR_W-1:0] next_wrPtr;
  logic [PTR_W-1:0] next_rdPtr;
  logic [PTR_W:0]   next_count;
  logic             doWrite;
  logic             doRead;

  assign inReady  = count != FULL_CNT;
  assign outValid = count != '0;
  assign outData  = mem[rdPtr];

  always_comb begin
    doWrite    = inValid && inReady;
    doRead     = outValid && outReady;
    next_wrPtr = doWrite ? ((wrPtr == LAST) ? '0 : wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRead ? ((rdPtr == LAST) ? '0 : rdPtr + 1'b1) : rdPtr;
    next_count = count + (PTR_W+1)'(doWrite) - (PTR_W+1)'(doRead);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule : sac_fifo
`default_nettype wire

// [rtl/sac_sequencer.sv]
// converter sequencer: modes, averaging, result packing, dma feed
`timescale 1ns/1ps
`default_nettype none
module sac_sequencer
  import sac_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // tasks
  input  wire logic                   startTask,
  input  wire logic                   sampleTask,
  input  wire logic                   stopTask,
  input  wire logic                   offsetCalibrationTask,
  // channel configuration
  input  wire logic [sac_pkg::NUM_CH-1:0][sac_pkg::SEL_W-1:0] posInputSelect,
  input  wire logic [sac_pkg::NUM_CH-1:0][sac_pkg::SEL_W-1:0] negInputSelect,
  input  wire sac_pkg::sac_chan_setup_t [sac_pkg::NUM_CH-1:0] channelSetup,
  // global configuration
  input  wire logic [1:0]             resolution,
  input  wire logic [sac_pkg::AVG_W-1:0] averagingLog2Count,
  input  wire logic                   localRateTimer,
  input  wire logic [sac_pkg::RATE_W-1:0] rateTimerCompare,
  input  wire logic [sac_pkg::ADDR_W-1:0] bufferPointer,
  input  wire logic [sac_pkg::CNT_W-1:0]  bufferCapacity,
  // analog front end
  output sac_pkg::sac_afe_req_t       afeReq,
  input  wire logic                   afeDone,
  input  wire logic [sac_pkg::CODE_W-1:0] afeCode,
  input  wire logic                   calDone,
  // dma write port
  output logic                        dmaValid,
  input  wire logic                   dmaReady,
  output sac_pkg::sac_dma_word_t      dmaWord,
  // events and status
  output sac_pkg::sac_events_t        events,
  output logic                        busy,
  output logic [sac_pkg::CNT_W-1:0]   transferredCount
);
  import sac_pkg::*;

  localparam int DMA_W = $bits(sac_dma_word_t);

  sac_seq_t          seq;
  sac_seq_t          next_seq;
  logic              next_dmaValid;
  sac_dma_word_t     next_dmaWord;
  logic [NUM_CH-1:0] enMask;
  logic              scanMode;
  logic              avgOn;
  logic              timerFire;
  logic [8:0]        avgLast;
  logic [SAMPLE_W-1:0] sample;
  logic signed [ACC_W-1:0] sum;
  logic [NUM_CH-1:0] remain;
  logic              fifoInValid;
  logic              fifoInReady;
  sac_dma_word_t     fifoInWord;
  logic              fifoOutValid;
  logic              fifoOutReady;
  logic [DMA_W-1:0]  fifoOutData;

  // lowest set channel in a mask
  function automatic logic [2:0] first_chan(input logic [NUM_CH-1:0] m);
    logic [2:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_chan

  function automatic int ones(input logic [NUM_CH-1:0] m);
    int n;
    n = 0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + int'(m[i]);
    end
    return n;
  endfunction : ones

  // saturate a front end code to the signed range of the setting
  function automatic logic [SAMPLE_W-1:0] fit_code(
    input logic [CODE_W-1:0] code,
    input logic [1:0]        res,
    input logic              avg,
    input logic              diff
  );
    int bits;
    int hi;
    int v;
    case (res)
      RES_8:   bits = BITS_8;
      RES_10:  bits = BITS_10;
      RES_12:  bits = BITS_12;
      default: bits = avg ? BITS_14 : BITS_12;
    endcase
    bits = diff ? bits - 1 : bits;
    hi = (1 << bits) - 1;
    v = int'($signed(code));
    if (v > hi) begin
      v = hi;
    end else if (v < -hi - 1) begin
      v = -hi - 1;
    end
    return SAMPLE_W'(v);
  endfunction : fit_code

  // average of an accumulated sum, keeping two extra bits for 14-bit when four or more samples are averaged
  function automatic logic [SAMPLE_W-1:0] average(
    input logic signed [ACC_W-1:0] s,
    input logic [AVG_W-1:0]        lg,
    input logic [1:0]              res
  );
    int sh;
    sh = int'(lg);
    if (res == RES_14 && sh >= EXTRA_14) begin
      sh = sh - EXTRA_14;
    end
    return SAMPLE_W'(s >>> sh);
  endfunction : average

  // load front end selection for one channel
  function automatic sac_afe_req_t afe_for(
    input logic [2:0] ch,
    input logic [NUM_CH-1:0][SEL_W-1:0] ps,
    input logic [NUM_CH-1:0][SEL_W-1:0] ns,
    input sac_chan_setup_t [NUM_CH-1:0] cs
  );
    sac_afe_req_t r;
    r = '0;
    r.posSel = ps[ch];
    r.negSel = cs[ch].diffMode ? ns[ch] : SEL_GND;
    r.setup  = cs[ch];
    return r;
  endfunction : afe_for

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      enMask[i] = posInputSelect[i] != SEL_NC;
    end
    scanMode  = ones(enMask) > 1;
    avgOn     = averagingLog2Count != '0;
    avgLast   = 9'((1 << averagingLog2Count) - 1);
    timerFire = seq.timerRun && seq.timer >= rateTimerCompare;
    sample    = fit_code(afeCode, resolution, avgOn,
                         channelSetup[seq.chan].diffMode);
    sum       = seq.acc + ACC_W'($signed(sample));
    remain    = seq.pending & ~(NUM_CH'(1) << seq.chan);
  end

  always_comb begin
    next_seq             = seq;
    next_seq.events      = '0;
    next_seq.afe.convert = 1'b0;
    fifoInValid          = 1'b0;
    fifoInWord           = '0;
    next_seq.timer = timerFire ? '0
                   : (seq.timerRun ? seq.timer + 1'b1 : '0);
    if (stopTask) begin
      next_seq.stopReq = 1'b1;
    end
    if (startTask && !seq.running) begin
      next_seq.running   = 1'b1;
      next_seq.base      = bufferPointer;
      next_seq.cap       = bufferCapacity;
      next_seq.wordIdx   = '0;
      next_seq.sampleCnt = '0;
      next_seq.halfFull  = 1'b0;
      next_seq.avgCnt    = '0;
      next_seq.acc       = '0;
      next_seq.events.started = 1'b1;
    end
    case (seq.state)
      S_IDLE: begin
        if (seq.stopReq) begin
          next_seq.state  = S_DRAIN;
          next_seq.ending = 1'b0;
        end else if (offsetCalibrationTask) begin
          next_seq.state         = S_CAL;
          next_seq.afe.calibrate = 1'b1;
        end else if (seq.running && (sampleTask || timerFire)
                     && enMask != '0) begin
          next_seq.pending = scanMode ? enMask
                           : NUM_CH'(1) << first_chan(enMask);
          next_seq.chan    = first_chan(enMask);
          next_seq.afe     = afe_for(first_chan(enMask), posInputSelect,
                                     negInputSelect, channelSetup);
          next_seq.afe.acquire = 1'b1;
          next_seq.acqCnt  =
            acq_cycles(channelSetup[first_chan(enMask)].acqTime);
          next_seq.state   = S_ACQ;
          if (localRateTimer && sampleTask) begin
            next_seq.timerRun = 1'b1;
          end
        end
      end
      S_ACQ: begin
        if (seq.stopReq) begin
          next_seq.afe   = '0;
          next_seq.state = S_DRAIN;
        end else if (seq.acqCnt <= ACQ_W'(1)) begin
          next_seq.afe.acquire = 1'b0;
          next_seq.afe.convert = 1'b1;
          next_seq.state       = S_CONV;
        end else begin
          next_seq.acqCnt = seq.acqCnt - 1'b1;
        end
      end
      S_CONV: begin
        if (seq.stopReq) begin
          next_seq.state = S_DRAIN;
        end else if (afeDone) begin
          next_seq.events.done = 1'b1;
          if (avgOn && seq.avgCnt != avgLast) begin
            next_seq.acc    = sum;
            next_seq.avgCnt = seq.avgCnt + 1'b1;
            if (channelSetup[seq.chan].burst) begin
              next_seq.afe.acquire = 1'b1;
              next_seq.acqCnt =
                acq_cycles(channelSetup[seq.chan].acqTime);
              next_seq.state  = S_ACQ;
            end else begin
              next_seq.state  = S_IDLE;
            end
          end else begin
            next_seq.result = avgOn
              ? average(sum, averagingLog2Count, resolution)
              : sample;
            next_seq.acc    = '0;
            next_seq.avgCnt = '0;
            next_seq.events.resultReady = 1'b1;
            next_seq.state  = S_STORE;
          end
        end
      end
      S_STORE: begin
        if (!seq.halfFull || fifoInReady) begin
          if (!seq.halfFull) begin
            next_seq.halfData = seq.result;
            next_seq.halfFull = 1'b1;
          end else begin
            fifoInValid       = 1'b1;
            fifoInWord.addr   = seq.base
              + ADDR_W'(seq.wordIdx) * ADDR_W'(BYTES_PER_WORD);
            fifoInWord.data   = {seq.result, seq.halfData};
            next_seq.halfFull = 1'b0;
            next_seq.wordIdx  = seq.wordIdx + 1'b1;
          end
          next_seq.sampleCnt = seq.sampleCnt + 1'b1;
          next_seq.pending   = remain;
          if (seq.sampleCnt + 1'b1 >= seq.cap) begin
            next_seq.state  = S_DRAIN;
            next_seq.ending = 1'b1;
          end else if (remain != '0 && !seq.stopReq) begin
            next_seq.chan    = first_chan(remain);
            next_seq.afe     = afe_for(first_chan(remain), posInputSelect,
                                       negInputSelect, channelSetup);
            next_seq.afe.acquire = 1'b1;
            next_seq.acqCnt  =
              acq_cycles(channelSetup[first_chan(remain)].acqTime);
            next_seq.state   = S_ACQ;
          end else begin
            next_seq.state = S_IDLE;
          end
        end
      end
      S_CAL: begin
        if (calDone) begin
          next_seq.afe.calibrate      = 1'b0;
          next_seq.events.calDone     = 1'b1;
          next_seq.state              = S_IDLE;
        end
      end
      S_DRAIN: begin
        next_seq.afe = '0;
        if (seq.halfFull) begin
          fifoInValid     = 1'b1;
          fifoInWord.addr = seq.base
            + ADDR_W'(seq.wordIdx) * ADDR_W'(BYTES_PER_WORD);
          fifoInWord.data = {{SAMPLE_W{1'b0}}, seq.halfData};
          if (fifoInReady) begin
            next_seq.halfFull = 1'b0;
            next_seq.wordIdx  = seq.wordIdx + 1'b1;
          end
        end else if (!fifoOutValid && !dmaValid) begin
          next_seq.running  = 1'b0;
          next_seq.timerRun = 1'b0;
          next_seq.stopReq  = stopTask;
          next_seq.pending  = '0;
          next_seq.avgCnt   = '0;
          next_seq.acc      = '0;
          next_seq.state    = S_IDLE;
          if (seq.ending && !seq.stopReq) begin
            next_seq.events.bufferEnd = 1'b1;
          end else begin
            next_seq.events.stopped = 1'b1;
          end
        end
      end
      default: begin
        next_seq = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      seq <= '0;
    end else begin
      seq <= next_seq;
    end
  end

  sac_fifo #(
    .WIDTH (DMA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInWord),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // output stage toward memory
  always_comb begin
    fifoOutReady  = !dmaValid || dmaReady;
    next_dmaValid = dmaValid && !dmaReady;
    next_dmaWord  = dmaWord;
    if (fifoOutReady && fifoOutValid) begin
      next_dmaValid = 1'b1;
      next_dmaWord  = sac_dma_word_t'(fifoOutData);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dmaValid <= 1'b0;
      dmaWord  <= '0;
    end else begin
      dmaValid <= next_dmaValid;
      dmaWord  <= next_dmaWord;
    end
  end

  assign afeReq           = seq.afe;
  assign events           = seq.events;
  assign busy             = seq.running;
  assign transferredCount = seq.sampleCnt;
endmodule : sac_sequencer
`default_nettype wire

// [verif/sac_afe_model.sv]
// front end and memory side model
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // front end
  input  wire sac_pkg::sac_afe_req_t   afeReq,
  output logic                         afeDone,
  output logic [sac_pkg::CODE_W-1:0]   afeCode,
  output logic                         calDone,
  output logic [sac_pkg::SEL_W-1:0]    lastNeg,
  // memory side
  output logic                         dmaReady
);
  import sac_pkg::*;
  logic [3:0]        convCnt;
  logic [3:0]        calCnt;
  logic [2:0]        tick;
  logic [CODE_W-1:0] code;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {convCnt, calCnt, tick, afeDone, calDone, dmaReady} <= '0;
      {afeCode, code, lastNeg} <= '0;
    end else begin
      tick     <= tick + 3'h1;
      dmaReady <= tick[1];
      afeDone  <= 1'b0;
      calDone  <= 1'b0;
      afeCode  <= ~afeCode;
      calCnt   <= afeReq.calibrate ? calCnt + 4'h1 : 4'h0;
      if (afeReq.calibrate && calCnt == 4'h8)
        calDone <= 1'b1;
      if (afeReq.convert) begin
        convCnt <= 4'h5;
        lastNeg <= afeReq.negSel;
        code    <= 16'h0020 + CODE_W'(afeReq.posSel);
      end else if (convCnt != 4'h0) begin
        convCnt <= convCnt - 4'h1;
        if (convCnt == 4'h1) begin
          afeDone <= 1'b1;
          afeCode <= code;
        end
      end
    end
  end
endmodule : sac_afe_model
`default_nettype wire

// [verif/sac_sequencer_asserts.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sac_sequencer_asserts
  import sac_pkg::*;
(
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rstn,
  // tasks and status
  input wire logic                       startTask,
  input wire logic                       stopTask,
  input wire logic                       busy,
  input wire logic [sac_pkg::AVG_W-1:0]  averagingLog2Count,
  // far side
  input wire sac_pkg::sac_afe_req_t      afeReq,
  input wire logic                       calDone,
  input wire logic                       dmaValid,
  input wire logic                       dmaReady,
  input wire sac_pkg::sac_dma_word_t     dmaWord,
  input wire sac_pkg::sac_events_t       events
);
  import sac_pkg::*;
  logic [9:0] acqLen;
  logic [9:0] next_acqLen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // acquisition length, held over the convert pulse
  always_comb begin
    next_acqLen = afeReq.acquire ? acqLen + 10'h1 :
                  (afeReq.convert ? acqLen : 10'h0);
  end
  always_ff @(posedge ref_clk) begin
    acqLen <= rstn ? next_acqLen : 10'h0;
  end
  a_start_started: assert property (
    startTask && !busy |=> events.started)
    else $error("start gave no started event");
  a_ready_with_done: assert property (
    events.resultReady |-> events.done)
    else $error("result ready without done");
  a_ready_no_avg: assert property (
    events.done && averagingLog2Count == 4'h0 |-> events.resultReady)
    else $error("done without result ready");
  a_acq_time: assert property (
    afeReq.convert && afeReq.setup.acqTime == 3'h0 |->
      acqLen inside {[10'd299:10'd301]})
    else $error("acquisition length wrong");
  a_neg_ground: assert property (
    afeReq.convert && !afeReq.setup.diffMode |-> afeReq.negSel == SEL_GND)
    else $error("single ended input not grounded");
  a_nc_skipped: assert property (
    afeReq.acquire |-> afeReq.posSel != SEL_NC)
    else $error("unconnected channel sampled");
  a_dma_hold: assert property (
    dmaValid && !dmaReady |=> dmaValid && $stable(dmaWord))
    else $error("dma word dropped before accept");
  a_cal_event: assert property (
    calDone && afeReq.calibrate |-> ##[1:2] events.calDone)
    else $error("no calibration event");
  a_stop_event: assert property (
    stopTask |-> ##[1:200] events.stopped)
    else $error("no stopped event");
  a_end_idle: assert property (
    events.bufferEnd |-> ##[0:1] !busy)
    else $error("busy after end");
endmodule : sac_sequencer_asserts
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic ref_clk, rstn, startTask, sampleTask, stopTask;
  logic offsetCalibrationTask, localRateTimer, afeDone, calDone;
  logic dmaValid, dmaReady, busy;
  logic [NUM_CH-1:0][SEL_W-1:0] posInputSelect, negInputSelect;
  sac_chan_setup_t [NUM_CH-1:0] channelSetup;
  logic [1:0]        resolution;
  logic [AVG_W-1:0]  averagingLog2Count;
  logic [RATE_W-1:0] rateTimerCompare;
  logic [ADDR_W-1:0] bufferPointer;
  logic [CNT_W-1:0]  bufferCapacity, transferredCount;
  logic [CODE_W-1:0] afeCode;
  logic [SEL_W-1:0]  lastNeg;
  sac_afe_req_t      afeReq;
  sac_dma_word_t     dmaWord;
  sac_events_t       events;
  sac_dma_word_t     words[$];
  int num_errors, checks, cyc, nStart, nDone, nRr, nEnd, nStop, nCal, n0;
  sac_sequencer #(.FIFO_DEPTH(4)) sac_sequencer_i (.ref_clk, .rstn,
    .startTask, .sampleTask, .stopTask, .offsetCalibrationTask,
    .posInputSelect, .negInputSelect, .channelSetup, .resolution,
    .averagingLog2Count, .localRateTimer, .rateTimerCompare,
    .bufferPointer, .bufferCapacity, .afeReq, .afeDone, .afeCode,
    .calDone, .dmaValid, .dmaReady, .dmaWord, .events, .busy,
    .transferredCount);
  sac_afe_model sac_afe_model_i (.ref_clk, .rstn, .afeReq, .afeDone,
    .afeCode, .calDone, .lastNeg, .dmaReady);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (events.started === 1'b1) nStart++;
    if (events.done === 1'b1) nDone++;
    if (events.resultReady === 1'b1) nRr++;
    if (events.bufferEnd === 1'b1) nEnd++;
    if (events.stopped === 1'b1) nStop++;
    if (events.calDone === 1'b1) nCal++;
    if (dmaValid === 1'b1 && dmaReady === 1'b1) words.push_back(dmaWord);
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: startTask <= 1'b1;
      1: sampleTask <= 1'b1;
      2: stopTask <= 1'b1;
      default: offsetCalibrationTask <= 1'b1;
    endcase
    @(posedge ref_clk);
    {startTask, sampleTask, stopTask, offsetCalibrationTask} <= 4'h0;
  endtask : pulse
  task automatic cfg(input logic [7:0] en, diff, brst, input int avg);
    @(posedge ref_clk);
    for (int i = 0; i < NUM_CH; i++) begin
      posInputSelect[i] <= en[i] ? SEL_W'(i + 1) : SEL_NC;
      negInputSelect[i] <= 4'h3;
      channelSetup[i] <= '{diffMode: diff[i], burst: brst[i], default: '0};
    end
    averagingLog2Count <= AVG_W'(avg);
  endtask : cfg
  task automatic clr();
    @(negedge ref_clk);
    {nStart, nDone, nRr, nEnd, nStop, nCal} = '0;
    words.delete();
  endtask : clr
  task automatic waitIdle();
    repeat (3) @(negedge ref_clk);
    while (busy !== 1'b0) @(negedge ref_clk);
    repeat (8) @(negedge ref_clk);
  endtask : waitIdle
  initial begin
    {rstn, startTask, sampleTask, stopTask, offsetCalibrationTask} = '0;
    {num_errors, checks, cyc, localRateTimer} = '0;
    {posInputSelect, negInputSelect, channelSetup} = '0;
    {averagingLog2Count, rateTimerCompare, bufferCapacity} = '0;
    resolution = RES_12;
    bufferPointer = 32'h2000_0000;
    clr();
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check("busy after reset", busy, 1'b0);
    check("events after reset", events, '0);
    pulse(2);
    waitIdle();
    check("stopped while idle", nStop, 1);
    pulse(3);
    while (nCal == 0) @(negedge ref_clk);
    check("calibrate released", afeReq.calibrate, 1'b0);
    clr();
    cfg(8'h26, 8'h20, 8'h00, 0);
    bufferCapacity <= 15'd3;
    pulse(0);
    bufferPointer <= 32'h2000_1000;
    pulse(1);
    pulse(0);
    waitIdle();
    check("start count", nStart, 1);
    check("scan done", nDone, 3);
    check("scan ready", nRr, 3);
    check("scan end", nEnd, 1);
    check("scan count", transferredCount, 3);
    check("diff negative", lastNeg, 4'h3);
    check("word0", words[0], {32'h2000_0000, 32'h0023_0022});
    check("word1", words[1], {32'h2000_0004, 32'h0000_0026});
    pulse(1);
    @(negedge ref_clk);
    check("sample after end", afeReq.acquire, 1'b0);
    clr();
    cfg(8'h01, 8'h00, 8'h01, 2);
    resolution <= RES_14;
    bufferCapacity <= 15'd1;
    pulse(0);
    pulse(1);
    waitIdle();
    check("burst done", nDone, 4);
    check("burst ready", nRr, 1);
    check("avg word", words[0], {32'h2000_1000, 32'h0000_0084});
    clr();
    cfg(8'h80, 8'h00, 8'h00, 0);
    resolution <= RES_8;
    pulse(0);
    pulse(1);
    waitIdle();
    check("oneshot ready", nRr, 1);
    check("oneshot", words[0], {32'h2000_1000, 32'h0000_0028});
    clr();
    cfg(8'h01, 8'h00, 8'h00, 0);
    resolution <= RES_12;
    localRateTimer <= 1'b1;
    rateTimerCompare <= 11'd600;
    bufferCapacity <= 15'd100;
    pulse(0);
    pulse(1);
    while (nDone < 3) @(negedge ref_clk);
    pulse(2);
    waitIdle();
    n0 = nDone;
    repeat (1500) @(negedge ref_clk);
    check("timer samples", nDone, 3);
    check("timer halted", nDone, n0);
    check("timer stopped", nStop, 1);
    check("timer count", transferredCount, 3);
    check("timer flush", words[1], {32'h2000_1004, 32'h0000_0021});
    summarize();
  end
endmodule : tb_top
bind sac_sequencer sac_sequencer_asserts sac_sequencer_asserts_i (
  .ref_clk, .rstn, .startTask, .stopTask, .busy, .averagingLog2Count,
  .afeReq, .calDone, .dmaValid, .dmaReady, .dmaWord, .events);
`default_nettype wire
